// File: inc/pin_port_pkg.sv
package pin_port_pkg;

  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned ADR_W = 8;

  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_OPTION = 8'h08;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'h00;
  localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic RST_GLOBAL_IRQ_ENABLE = 1'b0;

  localparam int unsigned CTRL_TRIG_LSB = 0;
  localparam int unsigned CTRL_TRIG_MSB = 1;
  localparam int unsigned CTRL_GLOBAL_EN_BIT = 4;

  typedef enum logic [1:0] {
    TRIG_FALLING = 2'h0,
    TRIG_RISING = 2'h1,
    TRIG_LOW = 2'h2
  } trig_mode_t;

  localparam trig_mode_t RST_TRIG_MODE = TRIG_FALLING;

endpackage

// File: inc/pin_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic [7:0] raw;
  logic [7:0] level;
  modport port_side (output raw, input level);
  modport sync_side (input raw, output level);
endinterface
`default_nettype wire

// File: hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  pin_sync_if.sync_side sif
);
  logic [7:0] meta_q;
  logic [7:0] level_q;

  // Second stage is the only reader of the first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 8'h00;
      level_q <= 8'h00;
    end else begin
      meta_q <= sif.raw;
      level_q <= meta_q;
    end
  end

  assign sif.level = level_q;
endmodule // pin_sync
`default_nettype wire

// File: hdl/pin_port.sv
`timescale 1ns/1ps
`default_nettype none
module pin_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_n_o,
  output logic [7:0] pull_up_en_o,
  output logic [7:0] analog_sel_o,
  output logic port_irq_req_o,
  output logic irq_o
);

  // Input with interrupt: direction 0, option 1, data 0
  function automatic logic [7:0] irq_pins(input logic [7:0] dir, input logic [7:0] opt, input logic [7:0] dat);
    irq_pins = ~dir & opt & ~dat;
  endfunction

  logic [7:0] port_pin_data_q;
  logic [7:0] port_pin_direction_q;
  logic [7:0] port_pin_option_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_status_d;
  logic [7:0] irq_mask_q;
  logic global_irq_enable_q;
  pin_port_pkg::trig_mode_t trig_mode_q;
  logic [7:0] level_prev_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic [7:0] pin_q;
  logic [7:0] pin_oe_n_q;
  logic [7:0] pull_up_q;
  logic [7:0] analog_q;
  logic port_req_q;
  logic irq_q;

  pin_sync_if sif ();

  assign sif.raw = pin_i;

  pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sif(sif)
  );

  wire [7:0] level = sif.level;
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  wire hit_data = wb_adr_i == pin_port_pkg::OFS_DATA;
  wire hit_dir = wb_adr_i == pin_port_pkg::OFS_DIRECTION;
  wire hit_opt = wb_adr_i == pin_port_pkg::OFS_OPTION;
  wire hit_ctrl = wb_adr_i == pin_port_pkg::OFS_IRQ_CTRL;
  wire hit_stat = wb_adr_i == pin_port_pkg::OFS_IRQ_STATUS;
  wire hit_mask = wb_adr_i == pin_port_pkg::OFS_IRQ_MASK;

  wire [7:0] data_view = (port_pin_direction_q & port_pin_data_q) | (~port_pin_direction_q & level);

  wire [7:0] ctrl_view = {3'h0, global_irq_enable_q, 2'h0, trig_mode_q};

  wire [7:0] rd_byte = hit_data ? data_view :
                       hit_dir ? port_pin_direction_q :
                       hit_opt ? port_pin_option_q :
                       hit_ctrl ? ctrl_view :
                       hit_stat ? irq_status_q :
                       hit_mask ? irq_mask_q : 8'h00;

  wire [7:0] fall = level_prev_q & ~level;
  wire [7:0] rise = ~level_prev_q & level;
  wire [7:0] trig = (trig_mode_q == pin_port_pkg::TRIG_RISING) ? rise :
                    (trig_mode_q == pin_port_pkg::TRIG_LOW) ? ~level : fall;

  wire [7:0] pin_event = trig & irq_pins(port_pin_direction_q, port_pin_option_q, port_pin_data_q)
                         & {8{global_irq_enable_q}};

  // Set wins over read-clear
  wire stat_clr = rd & hit_stat;
  assign irq_status_d = (stat_clr ? 8'h00 : irq_status_q) | pin_event;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_pin_data_q <= pin_port_pkg::RST_DATA;
      port_pin_direction_q <= pin_port_pkg::RST_DIRECTION;
      port_pin_option_q <= pin_port_pkg::RST_OPTION;
      irq_mask_q <= pin_port_pkg::RST_IRQ_MASK;
      global_irq_enable_q <= pin_port_pkg::RST_GLOBAL_IRQ_ENABLE;
      trig_mode_q <= pin_port_pkg::RST_TRIG_MODE;
    end else if (wr) begin
      if (hit_data) port_pin_data_q <= wb_dat_i[7:0];
      if (hit_dir) port_pin_direction_q <= wb_dat_i[7:0];
      if (hit_opt) port_pin_option_q <= wb_dat_i[7:0];
      if (hit_mask) irq_mask_q <= wb_dat_i[7:0];
      if (hit_ctrl) begin
        global_irq_enable_q <= wb_dat_i[pin_port_pkg::CTRL_GLOBAL_EN_BIT];
        // Unused code 3 folds to low level
        trig_mode_q <= (wb_dat_i[1:0] == 2'h3) ? pin_port_pkg::TRIG_LOW :
                       pin_port_pkg::trig_mode_t'(wb_dat_i[pin_port_pkg::CTRL_TRIG_MSB:pin_port_pkg::CTRL_TRIG_LSB]);
      end
    end
  end

  // Unmapped addresses still ack, read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      rdata_q <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_q <= pin_port_pkg::RST_IRQ_STATUS;
      level_prev_q <= 8'h00;
      port_req_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      level_prev_q <= level;
      port_req_q <= |pin_event;
      irq_q <= |(irq_status_d & irq_mask_q);
    end
  end

  genvar g;
  generate
    for (g = 0; g < pin_port_pkg::PIN_COUNT; g++) begin : g_pad
      wire dir = port_pin_direction_q[g];
      wire opt = port_pin_option_q[g];
      wire dat = port_pin_data_q[g];
      wire drive = dir & (opt | ~dat);
      wire pull = ~dir & ~dat;
      wire analog = ~dir & opt & dat;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_q[g] <= 1'b0;
          pin_oe_n_q[g] <= 1'b1;
          pull_up_q[g] <= 1'b1;
          analog_q[g] <= 1'b0;
        end else begin
          pin_q[g] <= dat & opt;
          pin_oe_n_q[g] <= ~drive;
          pull_up_q[g] <= pull;
          analog_q[g] <= analog;
        end
      end
    end
  endgenerate

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign pin_o = pin_q;
  assign pin_oe_n_o = pin_oe_n_q;
  assign pull_up_en_o = pull_up_q;
  assign analog_sel_o = analog_q;
  assign port_irq_req_o = port_req_q;
  assign irq_o = irq_q;

endmodule // pin_port
`default_nettype wire

// File: tb/pin_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pin_port_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic [7:0] pull_up_en_o,
  input wire logic [7:0] analog_sel_o,
  input wire logic port_irq_req_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property p_rst;
    $fell(rst_i) |-> pin_oe_n_o == 8'hff && pull_up_en_o == 8'hff && analog_sel_o == 8'h00 && !irq_o;
  endproperty
  property p_ack;
    s_req |=> wb_ack_o;
  endproperty
  property p_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_dat;
    wb_dat_o[31:8] == 24'h00_0000 && (wb_ack_o || wb_dat_o == 32'h0000_0000);
  endproperty
  property p_pu;
    (pull_up_en_o & ~pin_oe_n_o) == 8'h00;
  endproperty
  property p_an;
    (analog_sel_o & ~pin_oe_n_o) == 8'h00;
  endproperty
  property p_anpu;
    (analog_sel_o & pull_up_en_o) == 8'h00;
  endproperty
  // Only pulled-up inputs can request
  property p_req;
    port_irq_req_o |-> (pull_up_en_o & pin_oe_n_o) != 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_ack: assert property (p_ack) else $error("no ack");
  a_pulse: assert property (p_pulse) else $error("ack too long");
  a_dat: assert property (p_dat) else $error("read data not zero");
  a_pu: assert property (p_pu) else $error("pull-up on output");
  a_an: assert property (p_an) else $error("analog on output");
  a_anpu: assert property (p_anpu) else $error("pull-up on analog");
  a_req: assert property (p_req) else $error("request from wrong mode");
endmodule // pin_port_properties
bind pin_port pin_port_properties chk_u (.*);
`default_nettype wire

// File: tb/pin_world.sv
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  input wire logic clk_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic [7:0] pull_up_en_o,
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_i
);
  logic tgl_q = 1'b0;
  // Floating pad wanders, never holds
  always_ff @(posedge clk_i) tgl_q <= !tgl_q;
  assign pin_i = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & ext_en & ext_drv)
    | (pin_oe_n_o & ~ext_en & (pull_up_en_o | {8{tgl_q}}));
endmodule // pin_world
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, port_irq_req_o, irq_o;
  logic [7:0] wb_adr_i, pin_i, pin_o, pin_oe_n_o, pull_up_en_o, analog_sel_o, ext_drv, ext_en, d;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  int err_count, tests_run;
  pin_port dut_u (.*);
  pin_world world_u (.*);
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, v};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    d = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(n, d, e);
  endtask
  task automatic pin(input logic v);
    ext_drv[0] <= v;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_i);
    err_count++;
    report_and_stop;
  end
  initial begin
    {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i, ext_drv, ext_en} = {1'b1, 55'h0};
    wb_sel_i = 4'hf;
    err_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("pull", pull_up_en_o, 8'hff);
    rd("dir", pin_port_pkg::OFS_DIRECTION, 8'h00);
    rd("in", pin_port_pkg::OFS_DATA, 8'hff);
    rd("gap", 8'h3c, 8'h00);
    $display("test reset done");
    ext_en <= 8'h0f;
    ext_drv <= 8'h05;
    bus(1'b1, pin_port_pkg::OFS_DIRECTION, 8'hf0);
    bus(1'b1, pin_port_pkg::OFS_OPTION, 8'hcc);
    bus(1'b1, pin_port_pkg::OFS_DATA, 8'haa);
    repeat (3) @(posedge clk_i);
    chk("pull", pull_up_en_o, 8'h05);
    chk("analog", analog_sel_o, 8'h08);
    chk("oe", pin_oe_n_o, 8'h2f);
    chk("out", pin_o & ~pin_oe_n_o, 8'h80);
    rd("data", pin_port_pkg::OFS_DATA, 8'ha5);
    $display("test modes done");
    ext_en <= 8'h01;
    ext_drv <= 8'h01;
    bus(1'b1, pin_port_pkg::OFS_DIRECTION, 8'h00);
    bus(1'b1, pin_port_pkg::OFS_OPTION, 8'h01);
    bus(1'b1, pin_port_pkg::OFS_DATA, 8'h00);
    bus(1'b1, pin_port_pkg::OFS_IRQ_MASK, 8'h01);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, pin_port_pkg::OFS_IRQ_CTRL, 8'h10 | 8'(m));
      rd("idle", pin_port_pkg::OFS_IRQ_STATUS, 8'h00);
      pin(1'b0);
      chk("irq", {7'h0, irq_o}, {7'h0, m != 1});
      chk("req", {7'h0, port_irq_req_o}, {7'h0, m == 2});
      pin(1'b1);
      rd("stat", pin_port_pkg::OFS_IRQ_STATUS, 8'h01);
      @(posedge clk_i);
      chk("clr", {7'h0, irq_o}, 8'h00);
    end
    bus(1'b1, pin_port_pkg::OFS_IRQ_MASK, 8'h00);
    pin(1'b0);
    chk("mask", {7'h0, irq_o}, 8'h00);
    pin(1'b1);
    rd("stat", pin_port_pkg::OFS_IRQ_STATUS, 8'h01);
    bus(1'b1, pin_port_pkg::OFS_IRQ_CTRL, 8'h00);
    pin(1'b0);
    pin(1'b1);
    rd("gen", pin_port_pkg::OFS_IRQ_STATUS, 8'h00);
    $display("test irq done");
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
